// ### hw/arm_counter.sv
// arm_counter: count-mode timer or packet counter for one rule entry
`timescale 1ns/1ps
`default_nettype none
module arm_counter
    import arm_pkg::*;
#(
    parameter int COUNT_W = ARM_COUNT_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // configuration of this entry
    input  wire logic               active,
    input  wire logic               algorithm,
    input  wire logic [COUNT_W-1:0] count_value,
    // events
    input  wire logic               tick,
    input  wire logic               hit,
    output logic                    fire
);
    // -------------------------------------------------------------------
    // counter state
    // -------------------------------------------------------------------
    logic [COUNT_W-1:0] count;
    arm_cnt_state_t     state;

    // timer down-counts per unit; packet mode up-counts per hit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= ARM_COUNT_RST;
            state <= ARM_CNT_IDLE;
            fire  <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (!active) begin
                count <= ARM_COUNT_RST;
                state <= ARM_CNT_IDLE;
            end else if (!algorithm) begin
                // a qualifying packet reloads the timer
                case (state)
                    ARM_CNT_IDLE, ARM_CNT_DONE: begin
                        if (hit) begin
                            count <= count_value;
                            state <= ARM_CNT_RUN;
                        end
                    end
                    ARM_CNT_RUN: begin
                        if (hit) begin
                            count <= count_value;
                        end else if (tick) begin
                            if (count <= ARM_COUNT_ONE) begin
                                fire  <= 1'b1;
                                count <= ARM_COUNT_RST;
                                state <= ARM_CNT_DONE;
                            end else begin
                                count <= count - ARM_COUNT_ONE;
                            end
                        end
                    end
                    default: begin
                        state <= ARM_CNT_IDLE;
                    end
                endcase
            end else begin
                // time unit is not used in packet mode
                state <= ARM_CNT_RUN;
                if (hit) begin
                    if (count + ARM_COUNT_ONE >= count_value) begin
                        fire  <= 1'b1;
                        count <= ARM_COUNT_RST;
                    end else begin
                        count <= count + ARM_COUNT_ONE;
                    end
                end
            end
        end
    end
endmodule : arm_counter
`default_nettype wire

// ### hw/arm_pkg.sv
// arm_pkg: constants and types for the per-port acl rule match and action block
package arm_pkg;
    // -------------------------------------------------------------------
    // rule layer select and compare select codes
    // -------------------------------------------------------------------
    localparam logic [1:0] ARM_LAYER_OFF = 2'h0;
    localparam logic [1:0] ARM_LAYER_L2  = 2'h1;
    localparam logic [1:0] ARM_LAYER_L3  = 2'h2;
    localparam logic [1:0] ARM_LAYER_L4  = 2'h3;
    localparam logic [1:0] ARM_CMP_PROTO = 2'h0;
    localparam logic [1:0] ARM_CMP_TCP   = 2'h1;
    localparam logic [1:0] ARM_CMP_UDP   = 2'h2;
    localparam logic [1:0] ARM_CMP_SEQ   = 2'h3;
    localparam logic [1:0] ARM_CMP_COUNT = 2'h0;
    // -------------------------------------------------------------------
    // port range, priority and map mode codes
    // -------------------------------------------------------------------
    localparam logic [1:0] ARM_PC_OFF    = 2'h0;
    localparam logic [1:0] ARM_PC_EITHER = 2'h1;
    localparam logic [1:0] ARM_PC_IN     = 2'h2;
    localparam logic [1:0] ARM_PC_OUT    = 2'h3;
    localparam logic [1:0] ARM_PM_QOS    = 2'h0;
    localparam logic [1:0] ARM_PM_GT     = 2'h1;
    localparam logic [1:0] ARM_PM_LT     = 2'h2;
    localparam logic [1:0] ARM_PM_ALWAYS = 2'h3;
    localparam logic [1:0] ARM_MM_KEEP   = 2'h0;
    localparam logic [1:0] ARM_MM_OR     = 2'h1;
    localparam logic [1:0] ARM_MM_AND    = 2'h2;
    localparam logic [1:0] ARM_MM_REPL   = 2'h3;
    // -------------------------------------------------------------------
    // table shape, count widths and time bases
    // -------------------------------------------------------------------
    localparam int ARM_ENTRIES   = 16;
    localparam int ARM_IDX_W     = 4;
    localparam int ARM_COUNT_W   = 11;
    localparam int ARM_US_NS     = 1000;
    localparam int ARM_CLK_NS    = 5;
    localparam int ARM_US_CYCLES = ARM_US_NS / ARM_CLK_NS;
    localparam int ARM_MS_PER_US = 1000;
    localparam logic [ARM_COUNT_W-1:0] ARM_COUNT_RST = 11'h000;
    localparam logic [ARM_COUNT_W-1:0] ARM_COUNT_ONE = 11'h001;
    // count-mode timer states, binary coded
    typedef enum logic [1:0] {
        ARM_CNT_IDLE = 2'b00,
        ARM_CNT_RUN  = 2'b01,
        ARM_CNT_DONE = 2'b10
    } arm_cnt_state_t;
endpackage : arm_pkg

// ### hw/arm_rule_match_action.sv
// arm_rule_match_action: 16-entry acl matching and action logic for a port
`timescale 1ns/1ps
`default_nettype none
module arm_rule_match_action
    import arm_pkg::*;
#(
    parameter int ENTRIES = ARM_ENTRIES,
    parameter int PORTS   = 6,
    parameter int MS_DIV  = ARM_MS_PER_US
) (
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RST_B,
    // table write port
    input  wire logic               TBL_WR,
    input  wire logic [3:0]         TBL_IDX,
    input  wire logic [1:0]         TBL_LAYER_SELECT,
    input  wire logic [1:0]         TBL_COMPARE_SELECT,
    input  wire logic               TBL_SIDE_SOURCE,
    input  wire logic               TBL_MATCH_POLARITY,
    input  wire logic [31:0]        TBL_PORT_BOUNDS,
    input  wire logic [1:0]         TBL_PORT_RANGE_COMPARE,
    input  wire logic [7:0]         TBL_IP_NEXT_HEADER_VALUE,
    input  wire logic               TBL_TCP_FLAG_CHECK_ON,
    input  wire logic [7:0]         TBL_TCP_FLAG_IGNORE_BITS,
    input  wire logic [7:0]         TBL_TCP_FLAG_VALUE,
    input  wire logic [1:0]         TBL_PRIORITY_MODE,
    input  wire logic [2:0]         TBL_PRIORITY,
    input  wire logic               TBL_REMARK_ENABLE,
    input  wire logic [2:0]         TBL_REMARK_LEVEL,
    input  wire logic [1:0]         TBL_FORWARD_MAP_MODE,
    input  wire logic [PORTS-1:0]   TBL_FORWARD_MAP,
    input  wire logic               TBL_COUNT_TIME_UNIT,
    input  wire logic               TBL_COUNT_ALGORITHM,
    input  wire logic [7:0]         TBL_PROCESS,
    // parsed packet header
    input  wire logic               PKT_VALID,
    input  wire logic               PKT_L2_HIT,
    input  wire logic               PKT_L3_HIT,
    input  wire logic               PKT_IS_TCP,
    input  wire logic               PKT_IS_UDP,
    input  wire logic [7:0]         PKT_PROTOCOL,
    input  wire logic [15:0]        PKT_SRC_PORT,
    input  wire logic [15:0]        PKT_DST_PORT,
    input  wire logic [31:0]        PKT_TCP_SEQ,
    input  wire logic [7:0]         PKT_TCP_FLAGS,
    input  wire logic [2:0]         PKT_QOS_PRIORITY,
    input  wire logic [2:0]         PKT_VLAN_PCP,
    input  wire logic [PORTS-1:0]   PKT_LOOKUP_MAP,
    // action result
    output logic                    RES_VALID,
    output logic                    RES_HIT,
    output logic [2:0]              RES_PRIORITY,
    output logic [2:0]              RES_VLAN_PCP,
    output logic [PORTS-1:0]        RES_FORWARD_MAP,
    // interrupt status and masks
    input  wire logic [ENTRIES-1:0] INT_CLEAR,
    input  wire logic               PORT_INT_MASK,
    input  wire logic               GLOBAL_INT_MASK,
    output logic [ENTRIES-1:0]      INT_STATUS,
    output logic                    PORT_INT_STATUS,
    output logic                    GLOBAL_INT_STATUS,
    output logic                    INT_OUT
);
    // -------------------------------------------------------------------
    // rule table storage
    // -------------------------------------------------------------------
    logic [1:0]       t_layer [ENTRIES];
    logic [1:0]       t_cmp   [ENTRIES];
    logic             t_side  [ENTRIES];
    logic             t_pol   [ENTRIES];
    logic [31:0]      t_bound [ENTRIES];
    logic [1:0]       t_pc    [ENTRIES];
    logic [7:0]       t_proto [ENTRIES];
    logic             t_fme   [ENTRIES];
    logic [7:0]       t_tcp_flag_ignore_bits [ENTRIES];
    logic [7:0]       t_flag  [ENTRIES];
    logic [1:0]       t_pm    [ENTRIES];
    logic [2:0]       t_prio  [ENTRIES];
    logic             t_rpe   [ENTRIES];
    logic [2:0]       t_rp    [ENTRIES];
    logic [1:0]       t_mm    [ENTRIES];
    logic [PORTS-1:0] t_fwd   [ENTRIES];
    logic             t_tu    [ENTRIES];
    logic             t_ca    [ENTRIES];
    logic [7:0]       t_proc  [ENTRIES];

    // all fields of one entry are written together
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < ENTRIES; i++) begin
                t_layer[i] <= ARM_LAYER_OFF;
                t_cmp[i]   <= 2'h0;
                t_side[i]  <= 1'b0;
                t_pol[i]   <= 1'b0;
                t_bound[i] <= 32'h0000_0000;
                t_pc[i]    <= ARM_PC_OFF;
                t_proto[i] <= 8'h00;
                t_fme[i]   <= 1'b0;
                t_tcp_flag_ignore_bits[i] <= 8'h00;
                t_flag[i]  <= 8'h00;
                t_pm[i]    <= ARM_PM_QOS;
                t_prio[i]  <= 3'h0;
                t_rpe[i]   <= 1'b0;
                t_rp[i]    <= 3'h0;
                t_mm[i]    <= ARM_MM_KEEP;
                t_fwd[i]   <= '0;
                t_tu[i]    <= 1'b0;
                t_ca[i]    <= 1'b0;
                t_proc[i]  <= 8'h00;
            end
        end else if (TBL_WR) begin
            t_layer[TBL_IDX] <= TBL_LAYER_SELECT;
            t_cmp[TBL_IDX]   <= TBL_COMPARE_SELECT;
            t_side[TBL_IDX]  <= TBL_SIDE_SOURCE;
            t_pol[TBL_IDX]   <= TBL_MATCH_POLARITY;
            t_bound[TBL_IDX] <= TBL_PORT_BOUNDS;
            t_pc[TBL_IDX]    <= TBL_PORT_RANGE_COMPARE;
            t_proto[TBL_IDX] <= TBL_IP_NEXT_HEADER_VALUE;
            t_fme[TBL_IDX]   <= TBL_TCP_FLAG_CHECK_ON;
            t_tcp_flag_ignore_bits[TBL_IDX] <= TBL_TCP_FLAG_IGNORE_BITS;
            t_flag[TBL_IDX]  <= TBL_TCP_FLAG_VALUE;
            t_pm[TBL_IDX]    <= TBL_PRIORITY_MODE;
            t_prio[TBL_IDX]  <= TBL_PRIORITY;
            t_rpe[TBL_IDX]   <= TBL_REMARK_ENABLE;
            t_rp[TBL_IDX]    <= TBL_REMARK_LEVEL;
            t_mm[TBL_IDX]    <= TBL_FORWARD_MAP_MODE;
            t_fwd[TBL_IDX]   <= TBL_FORWARD_MAP;
            t_tu[TBL_IDX]    <= TBL_COUNT_TIME_UNIT;
            t_ca[TBL_IDX]    <= TBL_COUNT_ALGORITHM;
            t_proc[TBL_IDX]  <= TBL_PROCESS;
        end
    end

    // -------------------------------------------------------------------
    // per-entry matching
    // -------------------------------------------------------------------
    logic [ENTRIES-1:0] match;
    logic [ENTRIES-1:0] count_mode;

    // each entry matches on its own; the lowest matching entry acts
    always_comb begin
        logic [15:0] port;
        logic [15:0] hi;
        logic [15:0] lo;
        logic        eq;
        logic        range_ok;
        logic        flag_ok;
        port     = 16'h0000;
        hi       = 16'h0000;
        lo       = 16'h0000;
        eq       = 1'b0;
        range_ok = 1'b0;
        flag_ok  = 1'b0;
        for (int i = 0; i < ENTRIES; i++) begin
            count_mode[i] = (t_layer[i] == ARM_LAYER_L2) &&
                            (t_cmp[i] == ARM_CMP_COUNT);
            port = t_side[i] ? PKT_SRC_PORT : PKT_DST_PORT;
            hi   = t_bound[i][31:16];
            lo   = t_bound[i][15:0];
            case (t_pc[i])
                ARM_PC_EITHER: range_ok = (port == hi) || (port == lo);
                ARM_PC_IN:     range_ok = (port >= lo) && (port <= hi);
                ARM_PC_OUT:    range_ok = (port < lo) || (port > hi);
                default:       range_ok = 1'b1;
            endcase
            flag_ok = !t_fme[i] ||
                ((PKT_TCP_FLAGS & ~t_tcp_flag_ignore_bits[i]) ==
                 (t_flag[i] & ~t_tcp_flag_ignore_bits[i]));
            case (t_cmp[i])
                ARM_CMP_PROTO: eq = PKT_PROTOCOL == t_proto[i];
                ARM_CMP_TCP:   eq = PKT_IS_TCP && range_ok && flag_ok;
                ARM_CMP_UDP:   eq = PKT_IS_UDP && range_ok;
                ARM_CMP_SEQ:   eq = PKT_IS_TCP &&
                                    (PKT_TCP_SEQ == t_bound[i]) && flag_ok;
                default:       eq = 1'b0;
            endcase
            // layer 2 and layer 3 compares come pre-resolved
            case (t_layer[i])
                ARM_LAYER_L4: match[i] = PKT_VALID &&
                                         (eq == t_pol[i]);
                ARM_LAYER_L3: match[i] = PKT_VALID &&
                                         (PKT_L3_HIT == t_pol[i]);
                ARM_LAYER_L2: match[i] = PKT_VALID && !count_mode[i] &&
                                         (PKT_L2_HIT == t_pol[i]);
                default:      match[i] = 1'b0;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // action of the first matching entry
    // -------------------------------------------------------------------
    logic [ARM_IDX_W-1:0] sel;
    logic                 any;
    logic [2:0]           next_prio;
    logic [2:0]           next_pcp;
    logic [PORTS-1:0]     next_map;

    always_comb begin
        sel = '0;
        any = 1'b0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) begin
                sel = ARM_IDX_W'(i);
                any = 1'b1;
            end
        end
    end

    // count-mode entries never carry actions since match excludes them
    always_comb begin
        next_prio = PKT_QOS_PRIORITY;
        next_pcp  = PKT_VLAN_PCP;
        next_map  = PKT_LOOKUP_MAP;
        if (any) begin
            case (t_pm[sel])
                ARM_PM_GT: if (t_prio[sel] > PKT_QOS_PRIORITY) begin
                    next_prio = t_prio[sel];
                end
                ARM_PM_LT: if (t_prio[sel] < PKT_QOS_PRIORITY) begin
                    next_prio = t_prio[sel];
                end
                ARM_PM_ALWAYS: next_prio = t_prio[sel];
                default:       next_prio = PKT_QOS_PRIORITY;
            endcase
            if (t_rpe[sel]) begin
                next_pcp = t_rp[sel];
            end
            // bit 0 of the map stands for port 1
            case (t_mm[sel])
                ARM_MM_OR:   next_map = PKT_LOOKUP_MAP | t_fwd[sel];
                ARM_MM_AND:  next_map = PKT_LOOKUP_MAP & t_fwd[sel];
                ARM_MM_REPL: next_map = t_fwd[sel];
                default:     next_map = PKT_LOOKUP_MAP;
            endcase
        end
    end

    // result registered one cycle after the header
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RES_VALID       <= 1'b0;
            RES_HIT         <= 1'b0;
            RES_PRIORITY    <= 3'h0;
            RES_VLAN_PCP    <= 3'h0;
            RES_FORWARD_MAP <= '0;
        end else begin
            RES_VALID       <= PKT_VALID;
            RES_HIT         <= any;
            RES_PRIORITY    <= next_prio;
            RES_VLAN_PCP    <= next_pcp;
            RES_FORWARD_MAP <= next_map;
        end
    end

    // -------------------------------------------------------------------
    // time base: microsecond and millisecond ticks
    // -------------------------------------------------------------------
    logic [7:0] us_div;
    logic [9:0] ms_div;
    logic       us_tick;
    logic       ms_tick;

    // free running, so the first tick after arming may come up to a unit early
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            us_div  <= 8'h00;
            ms_div  <= 10'h000;
            us_tick <= 1'b0;
            ms_tick <= 1'b0;
        end else begin
            us_tick <= 1'b0;
            ms_tick <= 1'b0;
            if (us_div == 8'(ARM_US_CYCLES - 1)) begin
                us_div  <= 8'h00;
                us_tick <= 1'b1;
                if (ms_div == 10'(MS_DIV - 1)) begin
                    ms_div  <= 10'h000;
                    ms_tick <= 1'b1;
                end else begin
                    ms_div <= ms_div + 10'h001;
                end
            end else begin
                us_div <= us_div + 8'h01;
            end
        end
    end

    // -------------------------------------------------------------------
    // count-mode counters, one per entry
    // -------------------------------------------------------------------
    logic [ENTRIES-1:0] fire;

    for (genvar g = 0; g < ENTRIES; g++) begin : g_cnt
        arm_counter #(
            .COUNT_W (ARM_COUNT_W)
        ) u_cnt (
            .clk         (CLK),
            .rst_b       (RST_B),
            .active      (count_mode[g]),
            .algorithm   (t_ca[g]),
            .count_value ({t_pm[g], t_prio[g], t_rpe[g], t_rp[g],
                           t_mm[g]}),
            .tick        (t_tu[g] ? ms_tick : us_tick),
            .hit         (PKT_VALID && PKT_L2_HIT),
            .fire        (fire[g])
        );
    end

    // -------------------------------------------------------------------
    // interrupt status and masks
    // -------------------------------------------------------------------
    // set wins over clear so no expiry is lost
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            INT_STATUS <= '0;
        end else begin
            INT_STATUS <= (INT_STATUS & ~INT_CLEAR) | fire;
        end
    end

    // port level feeds the global level
    assign PORT_INT_STATUS   = |INT_STATUS;
    assign GLOBAL_INT_STATUS = PORT_INT_STATUS && !PORT_INT_MASK;
    assign INT_OUT           = GLOBAL_INT_STATUS && !GLOBAL_INT_MASK;
endmodule : arm_rule_match_action
`default_nettype wire

// ### test/arm_parser_model.sv
// ingress parser stand-in: presents one parsed header per request
`timescale 1ns/1ps
`default_nettype none
module arm_parser_model #(
    parameter int PORTS = 6
) (
    // clock
    input wire logic         CLK,
    // parsed header towards the block
    output logic             PKT_VALID,
    output logic             PKT_L2_HIT,
    output logic             PKT_L3_HIT,
    output logic             PKT_IS_TCP,
    output logic             PKT_IS_UDP,
    output logic [7:0]       PKT_PROTOCOL,
    output logic [15:0]      PKT_SRC_PORT,
    output logic [15:0]      PKT_DST_PORT,
    output logic [31:0]      PKT_TCP_SEQ,
    output logic [7:0]       PKT_TCP_FLAGS,
    output logic [2:0]       PKT_QOS_PRIORITY,
    output logic [2:0]       PKT_VLAN_PCP,
    output logic [PORTS-1:0] PKT_LOOKUP_MAP
);
    logic [89+PORTS:0] hdr = '0;
    initial PKT_VALID = 1'b0;
    // fields unpacked from one word so a release can invert them all
    assign {PKT_L2_HIT, PKT_L3_HIT, PKT_IS_TCP, PKT_IS_UDP, PKT_PROTOCOL,
            PKT_SRC_PORT, PKT_DST_PORT, PKT_TCP_SEQ, PKT_TCP_FLAGS,
            PKT_QOS_PRIORITY, PKT_VLAN_PCP, PKT_LOOKUP_MAP} = hdr;
    // header stands one cycle, then turns to its inverse, not a stale copy
    task automatic send(input logic l2, tcp, udp, input logic [7:0] pr,
                        input logic [15:0] sp, dp, input logic [2:0] qos);
        @(posedge CLK);
        #1;
        hdr = {l2, 1'b0, tcp, udp, pr, sp, dp, dp, sp, 8'h12, qos, 3'h5,
               PORTS'(6'h0c)};
        PKT_VALID = 1'b1;
        @(posedge CLK);
        #1;
        PKT_VALID = 1'b0;
        hdr = ~hdr;
    endtask
endmodule // arm_parser_model
`default_nettype wire

// ### test/arm_rule_match_action_properties.sv
// port-level checks for the acl rule match and action block
`timescale 1ns/1ps
`default_nettype none
module arm_rma_checker
    import arm_pkg::*;
#(
    parameter int ENTRIES = ARM_ENTRIES,
    parameter int PORTS   = 6
) (
    // clock, reset and packet side
    input wire logic               CLK,
    input wire logic               RST_B,
    input wire logic               PKT_VALID,
    input wire logic [PORTS-1:0]   PKT_LOOKUP_MAP,
    // results
    input wire logic               RES_VALID,
    input wire logic               RES_HIT,
    input wire logic [PORTS-1:0]   RES_FORWARD_MAP,
    // interrupt side
    input wire logic [ENTRIES-1:0] INT_CLEAR,
    input wire logic               PORT_INT_MASK,
    input wire logic               GLOBAL_INT_MASK,
    input wire logic [ENTRIES-1:0] INT_STATUS,
    input wire logic               PORT_INT_STATUS,
    input wire logic               GLOBAL_INT_STATUS,
    input wire logic               INT_OUT
);
    // one domain, so clock and reset are named once
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    property p_answer; PKT_VALID |=> RES_VALID; endproperty
    property p_quiet; !PKT_VALID ##1 !PKT_VALID |-> !RES_VALID; endproperty
    property p_hit_valid; RES_HIT |-> RES_VALID; endproperty
    property p_miss_keep;
        RES_VALID && !RES_HIT |-> RES_FORWARD_MAP == $past(PKT_LOOKUP_MAP);
    endproperty
    property p_port; PORT_INT_STATUS == (|INT_STATUS); endproperty
    property p_global;
        GLOBAL_INT_STATUS == (PORT_INT_STATUS && !PORT_INT_MASK);
    endproperty
    property p_out; INT_OUT == (GLOBAL_INT_STATUS && !GLOBAL_INT_MASK); endproperty
    // a set bit may only drop where a clear was asked for
    property p_sticky;
        1'b1 |=> (($past(INT_STATUS) & ~$past(INT_CLEAR) & ~INT_STATUS) == '0);
    endproperty
    a_answer: assert property (p_answer) else $error("no result");
    a_quiet: assert property (p_quiet) else $error("stray result");
    a_hit_valid: assert property (p_hit_valid) else $error("bad hit");
    a_miss_keep: assert property (p_miss_keep) else $error("map moved");
    a_port: assert property (p_port) else $error("port status");
    a_global: assert property (p_global) else $error("global status");
    a_out: assert property (p_out) else $error("interrupt out");
    a_sticky: assert property (p_sticky) else $error("status lost");
    c_hit: cover property (RES_HIT);
    c_irq: cover property ($rose(INT_OUT));
    c_clear: cover property ($fell(PORT_INT_STATUS));
endmodule // arm_rma_checker
bind arm_rule_match_action arm_rma_checker
    #(.ENTRIES(ENTRIES), .PORTS(PORTS)) u_chk (.*);
`default_nettype wire

// ### test/test_arm_rule_match_action.sv
// self-checking bench for the acl rule match and action block
`timescale 1ns/1ps
`default_nettype none
module test_arm_rule_match_action;
    import arm_pkg::*;
    localparam int PORTS = 6;
    logic CLK = 1'b0, RST_B = 1'b0, TBL_WR = 1'b0, TBL_SIDE_SOURCE = 1'b0;
    logic TBL_MATCH_POLARITY = 1'b0, TBL_REMARK_ENABLE = 1'b0;
    logic TBL_COUNT_ALGORITHM = 1'b0, PORT_INT_MASK = 1'b0;
    logic GLOBAL_INT_MASK = 1'b0, TBL_COUNT_TIME_UNIT = 1'b0;
    logic [1:0] TBL_LAYER_SELECT = 2'h0, TBL_COMPARE_SELECT = 2'h0;
    logic [1:0] TBL_PORT_RANGE_COMPARE = 2'h0, TBL_PRIORITY_MODE = 2'h0;
    logic [1:0] TBL_FORWARD_MAP_MODE = 2'h0;
    logic [2:0] TBL_PRIORITY = 3'h0, TBL_REMARK_LEVEL = 3'h0;
    logic [3:0] TBL_IDX = 4'h0;
    logic [7:0] TBL_IP_NEXT_HEADER_VALUE = 8'h00;
    logic [31:0] TBL_PORT_BOUNDS = 32'h0;
    logic [PORTS-1:0] TBL_FORWARD_MAP = 6'h21;
    logic [15:0] INT_CLEAR = 16'h0000;
    logic PKT_VALID, PKT_L2_HIT, PKT_L3_HIT, PKT_IS_TCP, PKT_IS_UDP;
    logic RES_VALID, RES_HIT, PORT_INT_STATUS, GLOBAL_INT_STATUS, INT_OUT;
    logic [7:0] PKT_PROTOCOL, PKT_TCP_FLAGS;
    logic [15:0] PKT_SRC_PORT, PKT_DST_PORT, INT_STATUS;
    logic [31:0] PKT_TCP_SEQ;
    logic [2:0] PKT_QOS_PRIORITY, PKT_VLAN_PCP, RES_PRIORITY, RES_VLAN_PCP;
    logic [PORTS-1:0] PKT_LOOKUP_MAP, RES_FORWARD_MAP;
    int failures = 0, checks_done = 0;
    // short millisecond divider keeps millisecond timer entries fast
    arm_rule_match_action #(.PORTS(PORTS), .MS_DIV(4)) DUT (.*,
        .TBL_TCP_FLAG_CHECK_ON(1'b0), .TBL_TCP_FLAG_IGNORE_BITS(8'hff),
        .TBL_TCP_FLAG_VALUE(8'h00), .TBL_PROCESS(8'h00));
    arm_parser_model #(.PORTS(PORTS)) u_par (.*);
    // 200 MHz clock
    always #2.5 CLK = ~CLK;
    task automatic end_of_test();
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // ac is the action word in count-value order: pm, prio, rpe, rp, mm
    task automatic wr(input logic [3:0] i, input logic [1:0] ly, cm,
        input logic sd, pl, input logic [31:0] bd, input logic [1:0] pc,
        input logic [7:0] pr, input logic [10:0] ac, input logic ca);
        @(posedge CLK);
        #1;
        {TBL_IDX, TBL_LAYER_SELECT, TBL_COMPARE_SELECT} = {i, ly, cm};
        {TBL_SIDE_SOURCE, TBL_MATCH_POLARITY, TBL_PORT_BOUNDS} = {sd, pl, bd};
        {TBL_PORT_RANGE_COMPARE, TBL_IP_NEXT_HEADER_VALUE} = {pc, pr};
        {TBL_PRIORITY_MODE, TBL_PRIORITY, TBL_REMARK_ENABLE, TBL_REMARK_LEVEL,
         TBL_FORWARD_MAP_MODE} = ac;
        TBL_COUNT_ALGORITHM = ca;
        TBL_WR = 1'b1;
        @(posedge CLK);
        #1;
        TBL_WR = 1'b0;
    endtask
    // one header, then compare {hit, priority, pcp, map}
    task automatic pkt(input logic l2, tcp, udp, input logic [7:0] pr,
        input logic [15:0] sp, dp, input logic [2:0] qos, input logic [12:0] e);
        u_par.send(l2, tcp, udp, pr, sp, dp, qos);
        chk({19'h0, RES_HIT, RES_PRIORITY, RES_VLAN_PCP, RES_FORWARD_MAP},
            {19'h0, e});
    endtask
    // masks {port, global} after an edge, then compare {port, global, out}
    task automatic msk(input logic [1:0] m, input logic [31:0] e);
        @(posedge CLK);
        #1;
        {PORT_INT_MASK, GLOBAL_INT_MASK} = m;
        #1;
        chk({29'h0, PORT_INT_STATUS, GLOBAL_INT_STATUS, INT_OUT}, e);
    endtask
    // watchdog: the whole run needs about 1,800 cycles
    initial begin
        #50000;
        failures++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge CLK);
        #1;
        RST_B = 1'b1;
        pkt(0, 1, 0, 8'h06, 16'h5000, 16'h0090, 3'h3, 13'h074c);
        wr(4'h0, ARM_LAYER_L4, ARM_CMP_TCP, 0, 1, 32'h0100_0080, ARM_PC_IN,
           8'h00, 11'h7eb, 0);
        pkt(0, 1, 0, 8'h06, 16'h5000, 16'h0090, 3'h3, 13'h1ea1);
        pkt(0, 1, 0, 8'h06, 16'h0090, 16'h0200, 3'h3, 13'h074c);
        pkt(0, 1, 0, 8'h06, 16'h5000, 16'h0100, 3'h0, 13'h1ea1);
        wr(4'h1, ARM_LAYER_L4, ARM_CMP_PROTO, 0, 1, 32'h0, ARM_PC_OFF,
           8'h11, 11'h301, 0);
        pkt(0, 0, 1, 8'h11, 16'h0, 16'h0, 3'h2, 13'h196d);
        pkt(0, 0, 1, 8'h11, 16'h0, 16'h0, 3'h6, 13'h1d6d);
        pkt(0, 0, 1, 8'h06, 16'h0, 16'h0, 3'h2, 13'h054c);
        wr(4'h1, ARM_LAYER_L4, ARM_CMP_PROTO, 0, 0, 32'h0, ARM_PC_OFF,
           8'h11, 11'h301, 0);
        pkt(0, 0, 1, 8'h06, 16'h0, 16'h0, 3'h2, 13'h196d);
        wr(4'h2, ARM_LAYER_L2, ARM_CMP_COUNT, 0, 1, 32'h0, ARM_PC_OFF,
           8'h00, 11'h003, 1);
        for (int n = 0; n < 3; n++) begin
            pkt(1, 0, 0, 8'h11, 16'h0, 16'h0, 3'h1, 13'h034c);
            chk({16'h0, INT_STATUS}, 32'h0);
        end
        repeat (2) @(posedge CLK);
        #1;
        chk({16'h0, INT_STATUS}, 32'h4);
        msk(2'h0, 32'h7);
        msk(2'h2, 32'h4);
        msk(2'h1, 32'h6);
        @(posedge CLK);
        #1;
        INT_CLEAR = 16'h0004;
        @(posedge CLK);
        #1;
        INT_CLEAR = 16'h0000;
        chk({16'h0, INT_STATUS}, 32'h0);
        // timer of 2 ms: no expiry before 800 cycles, one by 1,601
        TBL_COUNT_TIME_UNIT = 1'b1;
        wr(4'h3, ARM_LAYER_L2, ARM_CMP_COUNT, 0, 1, 32'h0, ARM_PC_OFF,
           8'h00, 11'h002, 0);
        pkt(1, 0, 0, 8'h11, 16'h0, 16'h0, 3'h1, 13'h034c);
        repeat (700) @(posedge CLK);
        #1;
        chk({16'h0, INT_STATUS}, 32'h0);
        repeat (1000) @(posedge CLK);
        #1;
        chk({16'h0, INT_STATUS}, 32'h8);
        end_of_test();
    end
endmodule // test_arm_rule_match_action
`default_nettype wire
